// [logic/efr_flag_registers.v]
// Datapath overflow, sticky event and live event flag registers with interrupt pulse output.
// What this block does
// - Overflow register bit 7 sets on left datapath overflow; zero after reset.
// - Overflow register bit 6 sets on right datapath overflow; zero after reset.
// - Overflow bit 5 sets on barrel shifter overflow; bits 4 to 0 read zero.
// - Sticky flags are read-only, clear on read, and set again only on new events.
// - Sticky bit 7 latches a left headphone or left speaker short; resets to zero.
// - Sticky bit 6 latches a right headphone or right speaker short; resets to zero.
// - Bit 5 shows headset button press in sticky and live registers.
// - Sticky bit 4 latches any headset insertion or removal.
// - Sticky bit 3 latches left power above compressor threshold; resets to zero.
// - Sticky bit 2 latches right power above compressor threshold; resets to zero.
// - Live bit 7 follows a left headphone or speaker short without latching.
// - Live bit 6 follows a right headphone or speaker short without latching.
// - Live bit 4 reads one after insertion and zero after removal.
// - Live bits 3 and 2 are one while left or right power exceeds threshold.
// - Repeat mode pulses the interrupt 2 ms every 4 ms until sticky read.
`timescale 1ns/1ps
`include "efr_defines.vh"
module efr_flag_registers #(
  parameter        SYNC_W     = 8,
  parameter [19:0] PULSE_CYC  = `EFR_PULSE_CYC,
  parameter [19:0] PERIOD_CYC = `EFR_PERIOD_CYC
) (
  input  wire                     clock,
  input  wire                     rstn,
  input  wire                     rd_en,
  input  wire [`EFR_ADDR_W-1:0]   rd_addr,
  output reg  [7:0]               rd_data,
  output reg                      rd_valid,
  output reg                      rd_hit,
  input  wire                     ovf_left_pulse,
  input  wire                     ovf_right_pulse,
  input  wire                     ovf_shift_pulse,
  input  wire                     short_hp_left,
  input  wire                     short_spk_left,
  input  wire                     short_hp_right,
  input  wire                     short_spk_right,
  input  wire                     button_level,
  input  wire                     headset_level,
  input  wire                     power_left_above,
  input  wire                     power_right_above,
  input  wire                     irq_en_headset,
  input  wire                     irq_en_button,
  input  wire                     irq_en_power,
  input  wire                     irq_en_short,
  input  wire                     irq_en_overflow,
  input  wire                     irq_repeat,
  output wire                     first_interrupt_output
);

  localparam SRC_SHORT_HP_L  = 0;
  localparam SRC_SHORT_SPK_L = 1;
  localparam SRC_SHORT_HP_R  = 2;
  localparam SRC_SHORT_SPK_R = 3;
  localparam SRC_BUTTON      = 4;
  localparam SRC_HEADSET     = 5;
  localparam SRC_POWER_L     = 6;
  localparam SRC_POWER_R     = 7;

  // True for every location of the flag group, reserved ones included.
  function in_group;
    input [`EFR_ADDR_W-1:0] addr;
    begin
      in_group = (addr >= `EFR_ADDR_OVERFLOW) && (addr <= `EFR_ADDR_LIVE);
    end
  endfunction

  wire [SYNC_W-1:0] raw_src;
  reg  [SYNC_W-1:0] sync1_q;
  reg  [SYNC_W-1:0] sync2_q;
  reg  [SYNC_W-1:0] sync3_q;
  reg  [SYNC_W-1:0] stable_q;
  reg  [SYNC_W-1:0] stable_d;
  reg  [SYNC_W-1:0] prev_q;

  reg  [7:0]        ovf_q;
  reg  [7:0]        ovf_d;
  reg  [7:0]        sticky_q;
  reg  [7:0]        sticky_d;
  reg  [7:0]        live_q;
  reg  [7:0]        live_d;
  reg  [7:0]        ovf_set;
  reg  [7:0]        sticky_set;
  reg  [7:0]        rd_data_d;

  wire              rd_ovf;
  wire              rd_sticky;
  wire              short_l_now;
  wire              short_r_now;
  wire              short_l_was;
  wire              short_r_was;
  wire              irq_trigger;

  assign raw_src[SRC_SHORT_HP_L]  = short_hp_left;
  assign raw_src[SRC_SHORT_SPK_L] = short_spk_left;
  assign raw_src[SRC_SHORT_HP_R]  = short_hp_right;
  assign raw_src[SRC_SHORT_SPK_R] = short_spk_right;
  assign raw_src[SRC_BUTTON]      = button_level;
  assign raw_src[SRC_HEADSET]     = headset_level;
  assign raw_src[SRC_POWER_L]     = power_left_above;
  assign raw_src[SRC_POWER_R]     = power_right_above;

  // Detector levels come from the analog side, so each passes three flops and
  // only moves once the last two agree; a single-cycle glitch never reaches a flag.
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1)
    begin : g_sync
      always @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= raw_src[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end

      always @*
      begin
        if (sync2_q[g] == sync3_q[g])
          stable_d[g] = sync3_q[g];
        else
          stable_d[g] = stable_q[g];
      end
    end
  endgenerate

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stable_q <= {SYNC_W{1'b0}};
      prev_q   <= {SYNC_W{1'b0}};
    end
    else
    begin
      stable_q <= stable_d;
      prev_q   <= stable_q;
    end
  end

  assign short_l_now = stable_q[SRC_SHORT_HP_L] | stable_q[SRC_SHORT_SPK_L];
  assign short_r_now = stable_q[SRC_SHORT_HP_R] | stable_q[SRC_SHORT_SPK_R];
  assign short_l_was = prev_q[SRC_SHORT_HP_L] | prev_q[SRC_SHORT_SPK_L];
  assign short_r_was = prev_q[SRC_SHORT_HP_R] | prev_q[SRC_SHORT_SPK_R];

  assign rd_ovf    = rd_en && (rd_addr == `EFR_ADDR_OVERFLOW);
  assign rd_sticky = rd_en && (rd_addr == `EFR_ADDR_STICKY);

  // Overflow events are strobes from the datapath on this clock and need no sync.
  always @*
  begin
    ovf_set                     = 8'h00;
    ovf_set[`EFR_BIT_OVF_LEFT]  = ovf_left_pulse;
    ovf_set[`EFR_BIT_OVF_RIGHT] = ovf_right_pulse;
    ovf_set[`EFR_BIT_OVF_SHIFT] = ovf_shift_pulse;
  end

  // Sticky sources fire on the onset of a condition (the headset on either edge), so a condition that is
  // still present after a read does not set its flag again until it recurs.
  always @*
  begin
    sticky_set                   = 8'h00;
    sticky_set[`EFR_BIT_SHORT_L] = short_l_now & ~short_l_was;
    sticky_set[`EFR_BIT_SHORT_R] = short_r_now & ~short_r_was;
    sticky_set[`EFR_BIT_BUTTON]  = stable_q[SRC_BUTTON] & ~prev_q[SRC_BUTTON];
    sticky_set[`EFR_BIT_HEADSET] = stable_q[SRC_HEADSET] ^ prev_q[SRC_HEADSET];
    sticky_set[`EFR_BIT_POWER_L] = stable_q[SRC_POWER_L] & ~prev_q[SRC_POWER_L];
    sticky_set[`EFR_BIT_POWER_R] = stable_q[SRC_POWER_R] & ~prev_q[SRC_POWER_R];
  end

  // Set wins over the read that clears, so no event is lost.
  always @*
  begin
    if (rd_ovf)
      ovf_d = ovf_set;
    else
      ovf_d = ovf_q | ovf_set;
    ovf_d[4:0] = 5'h00;
    if (rd_sticky)
      sticky_d = sticky_set;
    else
      sticky_d = sticky_q | sticky_set;
    sticky_d[1:0] = 2'h0;
  end

  always @*
  begin
    live_d                   = `EFR_RESET_LIVE;
    live_d[`EFR_BIT_SHORT_L] = short_l_now;
    live_d[`EFR_BIT_SHORT_R] = short_r_now;
    live_d[`EFR_BIT_BUTTON]  = stable_q[SRC_BUTTON];
    live_d[`EFR_BIT_HEADSET] = stable_q[SRC_HEADSET];
    live_d[`EFR_BIT_POWER_L] = stable_q[SRC_POWER_L];
    live_d[`EFR_BIT_POWER_R] = stable_q[SRC_POWER_R];
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ovf_q    <= `EFR_RESET_OVERFLOW;
      sticky_q <= `EFR_RESET_STICKY;
      live_q   <= `EFR_RESET_LIVE;
    end
    else
    begin
      ovf_q    <= ovf_d;
      sticky_q <= sticky_d;
      live_q   <= live_d;
    end
  end

  // Reads return the value held before the read; the clear lands on the same edge.
  always @*
  begin
    case (rd_addr)
      `EFR_ADDR_OVERFLOW:
        rd_data_d = ovf_q;
      `EFR_ADDR_STICKY:
        rd_data_d = sticky_q;
      `EFR_ADDR_LIVE:
        rd_data_d = live_q;
      default:
        rd_data_d = `EFR_RESET_RSVD;
    endcase
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      rd_hit   <= rd_en && in_group(rd_addr);
      if (rd_en)
        rd_data <= in_group(rd_addr) ? rd_data_d : 8'h00;
    end
  end

  // Each newly set flag whose class is enabled starts the interrupt output.
  assign irq_trigger =
    (irq_en_overflow && (ovf_set != 8'h00)) ||
    (irq_en_short && (sticky_set[`EFR_BIT_SHORT_L] || sticky_set[`EFR_BIT_SHORT_R])) ||
    (irq_en_button && sticky_set[`EFR_BIT_BUTTON]) ||
    (irq_en_headset && sticky_set[`EFR_BIT_HEADSET]) ||
    (irq_en_power && (sticky_set[`EFR_BIT_POWER_L] || sticky_set[`EFR_BIT_POWER_R]));

  efr_pulse_train #(
    .CNT_W      (20),
    .PULSE_CYC  (PULSE_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_pulse (
    .clock       (clock),
    .rstn        (rstn),
    .trigger     (irq_trigger),
    .repeat_mode (irq_repeat),
    .stop        (rd_sticky),
    .pulse_q     (first_interrupt_output)
  );

endmodule // efr_flag_registers

// [logic/efr_defines.vh]
// Register offsets, field positions, reset values and timing constants of the flag registers.
`ifndef EFR_DEFINES_VH
`define EFR_DEFINES_VH

`define EFR_ADDR_W         7
`define EFR_ADDR_OVERFLOW  7'h27
`define EFR_ADDR_RSVD_A    7'h28
`define EFR_ADDR_RSVD_B    7'h29
`define EFR_ADDR_RSVD_C    7'h2A
`define EFR_ADDR_RSVD_D    7'h2B
`define EFR_ADDR_STICKY    7'h2C
`define EFR_ADDR_RSVD_E    7'h2D
`define EFR_ADDR_LIVE      7'h2E

`define EFR_BIT_OVF_LEFT   7
`define EFR_BIT_OVF_RIGHT  6
`define EFR_BIT_OVF_SHIFT  5
`define EFR_BIT_SHORT_L    7
`define EFR_BIT_SHORT_R    6
`define EFR_BIT_BUTTON     5
`define EFR_BIT_HEADSET    4
`define EFR_BIT_POWER_L    3
`define EFR_BIT_POWER_R    2

`define EFR_RESET_OVERFLOW 8'h00
`define EFR_RESET_STICKY   8'h00
`define EFR_RESET_LIVE     8'h00
`define EFR_RESET_RSVD     8'h00

`define EFR_CLK_KHZ        200000
`define EFR_PULSE_MS       2
`define EFR_PERIOD_MS      4

// Pulse and period lengths in cycles of the 200 MHz clock, sized to the 20-bit counter.
`define EFR_PULSE_CYC      20'h61A80
`define EFR_PERIOD_CYC     20'hC3500

`endif

// [logic/efr_pulse_train.v]
// Interrupt pulse generator: one pulse, or a repeating train stopped by software.
`timescale 1ns/1ps
module efr_pulse_train #(
  parameter        CNT_W      = 20,
  parameter [19:0] PULSE_CYC  = 20'h61A80,
  parameter [19:0] PERIOD_CYC = 20'hC3500
) (
  input  wire clock,
  input  wire rstn,
  input  wire trigger,
  input  wire repeat_mode,
  input  wire stop,
  output reg  pulse_q
);

  reg             active_q;
  reg [CNT_W-1:0] cnt_q;
  reg             active_d;
  reg [CNT_W-1:0] cnt_d;
  reg             pulse_d;

  always @*
  begin
    active_d = active_q;
    cnt_d    = cnt_q;
    if (trigger && !active_q)
    begin
      active_d = 1'b1;
      cnt_d    = {CNT_W{1'b0}};
    end
    else if (active_q)
    begin
      // A new event outranks the stop that arrives with it, so it still gets its pulse.
      if (stop && !trigger)
      begin
        active_d = 1'b0;
        cnt_d    = {CNT_W{1'b0}};
      end
      else if (repeat_mode && cnt_q == PERIOD_CYC - 20'h00001)
      begin
        cnt_d = {CNT_W{1'b0}};
      end
      else if (!repeat_mode && cnt_q >= PULSE_CYC - 20'h00001)
      begin
        active_d = 1'b0;
        cnt_d    = {CNT_W{1'b0}};
      end
      else
      begin
        cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    pulse_d = active_d && (cnt_d < PULSE_CYC);
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      active_q <= 1'b0;
      cnt_q    <= {CNT_W{1'b0}};
      pulse_q  <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      cnt_q    <= cnt_d;
      pulse_q  <= pulse_d;
    end
  end

endmodule // efr_pulse_train

// [tb/efr_checker.sv]
// Concurrent checks on the flag register read port and event latching.
`timescale 1ns/1ps
module efr_checker (
  input wire       clock,
  input wire       rstn,
  input wire       rd_en,
  input wire [6:0] rd_addr,
  input wire [7:0] rd_data,
  input wire       rd_valid,
  input wire       rd_hit,
  input wire       ovf_left_pulse,
  input wire       short_hp_left,
  input wire       short_spk_left
);
  wire rd_ovf  = rd_en && rd_addr == 7'h27;
  wire rd_live = rd_en && rd_addr == 7'h2E;
  wire shl     = short_hp_left || short_spk_left;
  wire in_map  = rd_addr >= 7'h27 && rd_addr <= 7'h2E;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_fresh;
    (rd_ovf && !ovf_left_pulse) ##1 (!rd_en && !ovf_left_pulse) ##1 rd_ovf;
  endsequence
  sequence s_racing;
    (rd_ovf && ovf_left_pulse) ##1 !rd_en ##1 rd_ovf;
  endsequence
  property p_answer; rd_en |=> rd_valid; endproperty
  property p_quiet; !rd_en |=> !rd_valid; endproperty
  property p_hit; rd_en && in_map |=> rd_hit; endproperty
  property p_miss; rd_en && !in_map |=> !rd_hit && rd_data == 8'h00; endproperty
  property p_ovf_rsvd; rd_ovf |=> rd_data[4:0] == 5'h00; endproperty
  property p_ovf_set; ovf_left_pulse ##1 !rd_en ##1 rd_ovf |=> rd_data[7]; endproperty
  property p_clear; s_fresh |=> !rd_data[7]; endproperty
  property p_keep; s_racing |=> rd_data[7]; endproperty
  property p_live_on; shl [*6] ##0 rd_live |=> rd_data[7]; endproperty
  property p_live_off; !shl [*6] ##0 rd_live |=> !rd_data[7]; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  a_quiet: assert property (p_quiet) else $error("answer without read");
  a_hit: assert property (p_hit) else $error("mapped read without hit");
  a_miss: assert property (p_miss) else $error("unmapped read misanswered");
  a_ovf_rsvd: assert property (p_ovf_rsvd) else $error("low overflow bits set");
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not latched");
  a_clear: assert property (p_clear) else $error("flag not cleared by read");
  a_keep: assert property (p_keep) else $error("racing event lost");
  a_live_on: assert property (p_live_on) else $error("live short missing");
  a_live_off: assert property (p_live_off) else $error("live short stuck");
endmodule // efr_checker

// [tb/efr_host_model.sv]
// Polling host that issues single reads on the flag register port.
`timescale 1ns/1ps
module efr_host_model (
  input  wire       clock,
  output reg        rd_en,
  output reg  [6:0] rd_addr,
  input  wire [7:0] rd_data,
  input  wire       rd_valid
);
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
  end
  // Mapped flags and one unmapped probe only; the reserved slots are never read.
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(posedge clock);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      #1;
      d = rd_valid ? rd_data : 8'hXX;
    end
  endtask
endmodule // efr_host_model

// [tb/efr_flag_registers_tb.sv]
// Self-checking bench for the flag register group.
`timescale 1ns/1ps
module efr_flag_registers_tb;
  reg        clock;
  reg        rstn;
  wire       rd_en;
  wire [6:0] rd_addr;
  wire [7:0] rd_data;
  wire       rd_valid;
  wire       irq;
  reg  [2:0] ovf;
  reg  [3:0] shrt;
  reg  [1:0] pwr;
  reg  [5:0] en;
  reg        button;
  reg        headset;
  reg  [7:0] d;
  integer    fails;
  integer    compares;
  integer    n;
  efr_flag_registers #(.PULSE_CYC(20'h00004), .PERIOD_CYC(20'h00008)) i_efr_flag_registers (
    .clock(clock), .rstn(rstn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(), .ovf_left_pulse(ovf[2]), .ovf_right_pulse(ovf[1]),
    .ovf_shift_pulse(ovf[0]), .short_hp_left(shrt[3]), .short_spk_left(shrt[2]),
    .short_hp_right(shrt[1]), .short_spk_right(shrt[0]), .button_level(button),
    .headset_level(headset), .power_left_above(pwr[1]), .power_right_above(pwr[0]),
    .irq_en_headset(en[0]), .irq_en_button(en[1]), .irq_en_power(en[2]),
    .irq_en_short(en[3]), .irq_en_overflow(en[4]), .irq_repeat(en[5]),
    .first_interrupt_output(irq));
  efr_host_model i_efr_host_model (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid));
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rc(input [6:0] a, input [7:0] e);
    begin
      i_efr_host_model.rd(a, d);
      cmp($sformatf("reg %h", a), e, d);
    end
  endtask
  task irq_cycles;
    begin
      n = 0;
      repeat (16)
      begin
        @(posedge clock);
        #1;
        n = n + irq;
      end
    end
  endtask
  task give_verdict;
    begin
      $display("Mismatches %0d, compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    #20000;
    fails = fails + 1;
    give_verdict;
  end
  initial
  begin
    fails = 0;
    compares = 0;
    rstn = 1'b0;
    ovf = 3'h0;
    shrt = 4'h0;
    pwr = 2'h0;
    button = 1'b0;
    headset = 1'b0;
    en = 6'h28;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (8) @(posedge clock);
    rc(7'h27, 8'h00);
    rc(7'h2C, 8'h00);
    rc(7'h2E, 8'h00);
    rc(7'h30, 8'h00);
    @(posedge clock);
    ovf <= 3'h7;
    @(posedge clock);
    ovf <= 3'h0;
    rc(7'h27, 8'hE0);
    rc(7'h27, 8'h00);
    fork
      rc(7'h27, 8'h00);
      begin
        @(posedge clock);
        ovf <= 3'h4;
        @(posedge clock);
        ovf <= 3'h0;
      end
    join
    rc(7'h27, 8'h80);
    @(posedge clock);
    shrt <= 4'h9;
    pwr <= 2'h3;
    button <= 1'b1;
    headset <= 1'b1;
    repeat (10) @(posedge clock);
    irq_cycles;
    cmp("irq high cycles", 8'h08, n[7:0]);
    rc(7'h2C, 8'hFC);
    irq_cycles;
    cmp("irq after read", 8'h00, n[7:0]);
    rc(7'h2E, 8'hFC);
    rc(7'h2C, 8'h00);
    @(posedge clock);
    headset <= 1'b0;
    repeat (8) @(posedge clock);
    rc(7'h2C, 8'h10);
    rc(7'h2E, 8'hEC);
    @(posedge clock);
    shrt <= 4'h0;
    pwr <= 2'h0;
    button <= 1'b0;
    repeat (8) @(posedge clock);
    rc(7'h2E, 8'h00);
    @(posedge clock);
    shrt <= 4'h6;
    repeat (8) @(posedge clock);
    rc(7'h2C, 8'hC0);
    rc(7'h2E, 8'hC0);
    // Single-pulse mode with every other interrupt class enabled, one class at a time.
    @(posedge clock);
    en <= 6'h17;
    ovf <= 3'h1;
    fork
      irq_cycles;
      @(posedge clock) ovf <= 3'h0;
    join
    cmp("irq single pulse overflow", 8'h04, n[7:0]);
    rc(7'h27, 8'h20);
    @(posedge clock);
    button <= 1'b1;
    repeat (4) @(posedge clock);
    irq_cycles;
    cmp("irq single pulse button", 8'h04, n[7:0]);
    rc(7'h2C, 8'h20);
    @(posedge clock);
    headset <= 1'b1;
    repeat (4) @(posedge clock);
    irq_cycles;
    cmp("irq single pulse headset", 8'h04, n[7:0]);
    rc(7'h2C, 8'h10);
    @(posedge clock);
    pwr <= 2'h1;
    repeat (4) @(posedge clock);
    irq_cycles;
    cmp("irq single pulse power", 8'h04, n[7:0]);
    rc(7'h2C, 8'h04);
    give_verdict;
  end
endmodule // efr_flag_registers_tb
bind efr_flag_registers efr_checker i_efr_checker (
  .clock(clock), .rstn(rstn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_hit(rd_hit), .ovf_left_pulse(ovf_left_pulse),
  .short_hp_left(short_hp_left), .short_spk_left(short_spk_left));
